// [logic/bcu_pkg.sv]
`default_nettype none
package bcu_pkg;

  // ----------------------------------------------------------------
  // Register byte addresses
  // ----------------------------------------------------------------
  localparam logic [7:0] BCU_CTRL_OFS       = 8'h00;
  localparam logic [7:0] BCU_SRC_LO_OFS     = 8'h04;
  localparam logic [7:0] BCU_SRC_HI_OFS     = 8'h08;
  localparam logic [7:0] BCU_ADDEND_OFS     = 8'h0c;
  localparam logic [7:0] BCU_COLUMN_OFS     = 8'h10;
  localparam logic [7:0] BCU_DEST_BASE_OFS  = 8'h14;
  localparam logic [7:0] BCU_AREA_LIMIT_OFS = 8'h18;
  localparam logic [7:0] BCU_IND_CTRL_OFS   = 8'h1c;
  localparam logic [7:0] BCU_IND_PTR_OFS    = 8'h20;
  localparam logic [7:0] BCU_FLAGS_OFS      = 8'h24;
  localparam logic [7:0] BCU_RES_LO_OFS     = 8'h28;
  localparam logic [7:0] BCU_RES_HI_OFS     = 8'h2c;
  localparam logic [1:0] BCU_COL_WIN        = 2'h1;  // Addr[7:6] of set window 0x40..0x7c

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int BCU_CTRL_DIFF_BIT = 3;
  localparam int BCU_CTRL_COND_BIT = 4;
  localparam int BCU_FLAG_CY_BIT   = 0;
  localparam int BCU_FLAG_ZF_BIT   = 1;
  localparam int BCU_FLAG_UF_BIT   = 2;
  localparam int BCU_FLAG_ER_BIT   = 3;
  localparam int BCU_IND_EN_BIT    = 0;
  localparam int BCU_IND_MISS_BIT  = 1;

  // ----------------------------------------------------------------
  // Values and reset contents
  // ----------------------------------------------------------------
  localparam logic [15:0] BCU_ZERO16     = 16'h0000;
  localparam logic [31:0] BCU_ZERO32     = 32'h0000_0000;
  localparam logic [15:0] BCU_MIN_NEG16  = 16'h8000;
  localparam logic [31:0] BCU_MIN_NEG32  = 32'h8000_0000;
  localparam logic [15:0] BCU_MAX_COLUMN = 16'h0015;
  localparam logic [16:0] BCU_SET_SPAN   = 17'h0000f;
  localparam logic [15:0] BCU_LIMIT_RST  = 16'hffff;
  localparam logic [4:0]  BCU_DIGIT_MAX  = 5'h09;
  localparam logic [4:0]  BCU_DIGIT_BASE = 5'h0a;
  localparam logic [3:0]  BCU_TENS_STEP  = 4'ha;

  typedef enum logic [2:0] {
    BCU_OP_NONE,
    BCU_OP_SCATTER,
    BCU_OP_NEG1,
    BCU_OP_NEG2,
    BCU_OP_SETC,
    BCU_OP_CLRC,
    BCU_OP_BCDADD
  } bcu_op_t;

endpackage
`default_nettype wire

// [logic/bcu_unit.sv]
// Summary of operation
// - Scatter with execution condition low changes no destination word or flag.
// - Scatter writes source bit i into column C of destination word D+i.
// - Column not BCD or above 15 sets error and skips the scatter.
// - Destination D through D+15 outside one data area sets error.
// - After scatter, zero flag shows whether the source word is zero.
// - Single negate writes 0000 minus source to the result word.
// - Single negate: zero flag on only for a zero result.
// - Single negate: underflow on only for source 8000, result stays 8000.
// - Double negate: S+1 high, S low; result high in R+1, low in R.
// - Double negate: zero flag on only when the full 32-bit result is zero.
// - Double negate: underflow on only for 8000 0000, passed through unchanged.
// - Missing, non-BCD or out-of-area indirect pointer sets the error flag, except on set-carry and clear-carry.
// - Set-carry forces carry on when its condition is true, else nothing.
// - Clear-carry forces carry off when its condition is true, else nothing.
// - BCD add sums augend, addend, carry; keeps four digits, carry above 9999.
// - BCD add with a non-BCD digit in either operand sets error.
// - After BCD add, zero flag shows whether the stored result is zero.
//
// Local design decisions: the register offsets and register access over Wishbone.
`timescale 1ns/1ns
`default_nettype none
module bcu_unit (
  input  wire logic        sys_clk,
  input  wire logic        rstn,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  output logic             carry_flag,
  output logic             zero_flag,
  output logic             underflow_flag,
  output logic             error_flag
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic                ack;
    logic [31:0]         rdat;
    bcu_pkg::bcu_op_t    op;
    logic                diff;
    logic                cond;
    logic                prev_cond;
    logic [15:0]         src_lo;
    logic [15:0]         src_hi;
    logic [15:0]         addend;
    logic [15:0]         column;
    logic [15:0]         dest_base;
    logic [15:0]         area_limit;
    logic [1:0]          ind_ctrl;
    logic [15:0]         ind_ptr;
    logic                cy;
    logic                zf;
    logic                uf;
    logic                er;
    logic [15:0]         res_lo;
    logic [15:0]         res_hi;
    logic [15:0][15:0]   col;
  } bcu_state_t;

  bcu_state_t s;
  bcu_state_t next_s;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // True when all four nibbles are decimal digits
  function automatic logic bcu_bcd_ok(input logic [15:0] v);
    logic ok;
    ok = 1'b1;
    for (int d = 0; d < 4; d++) begin
      if ({1'b0, v[4*d +: 4]} > bcu_pkg::BCU_DIGIT_MAX) begin
        ok = 1'b0;
      end
    end
    return ok;
  endfunction

  // Four-digit BCD add with carry in; returns {carry, digits}
  function automatic logic [16:0] bcu_bcd_add(input logic [15:0] a,
                                               input logic [15:0] b,
                                               input logic        ci);
    logic [4:0]  dsum;
    logic        c;
    logic [15:0] r;
    c = ci;
    r = bcu_pkg::BCU_ZERO16;
    for (int d = 0; d < 4; d++) begin
      dsum = {1'b0, a[4*d +: 4]} + {1'b0, b[4*d +: 4]} + {4'h0, c};
      c    = (dsum > bcu_pkg::BCU_DIGIT_MAX);
      if (c) begin
        dsum = dsum - bcu_pkg::BCU_DIGIT_BASE;
      end
      r[4*d +: 4] = dsum[3:0];
    end
    return {c, r};
  endfunction

  // Byte-lane merge for the 16-bit registers
  function automatic logic [15:0] bcu_merge(input logic [15:0] old,
                                            input logic [31:0] dat,
                                            input logic [3:0]  sel);
    logic [15:0] r;
    r = old;
    if (sel[0]) begin
      r[7:0] = dat[7:0];
    end
    if (sel[1]) begin
      r[15:8] = dat[15:8];
    end
    return r;
  endfunction

  // Two-digit BCD column (already checked to be 00..15) to bit index
  function automatic logic [3:0] bcu_col_idx(input logic [15:0] c);
    return c[4] ? bcu_pkg::BCU_TENS_STEP + c[3:0] : c[3:0];
  endfunction

  // ----------------------------------------------------------------
  // Decode and operand checks
  // ----------------------------------------------------------------
  // Declared ahead of its first use in the negate datapath
  localparam logic [15:0] BCU_Z16 = bcu_pkg::BCU_ZERO16;

  logic             req;
  logic             wr;
  logic [7:0]       wadr;
  logic             wr_ctrl;
  bcu_pkg::bcu_op_t new_op;
  logic             new_cond;
  logic             new_diff;
  logic             run;
  logic             ind_err;
  logic             col_err;
  logic             area_err;
  logic             add_err;
  logic [3:0]       cidx;
  logic [15:0]      neg16;
  logic [31:0]      neg32;
  logic [16:0]      bsum;

  // Writes land on the edge where the master samples ack
  assign req      = wb_cyc_i & wb_stb_i;
  assign wr       = req & wb_we_i & s.ack;
  assign wadr     = {wb_adr_i[7:2], 2'b00};
  assign wr_ctrl  = wr & (wadr == bcu_pkg::BCU_CTRL_OFS) & wb_sel_i[0];
  assign new_op   = bcu_pkg::bcu_op_t'(wb_dat_i[2:0]);
  assign new_cond = wb_dat_i[bcu_pkg::BCU_CTRL_COND_BIT];
  assign new_diff = wb_dat_i[bcu_pkg::BCU_CTRL_DIFF_BIT];
  // Plain form runs every scan with the condition high; edge form only on a rising condition
  assign run      = new_cond & (~new_diff | ~s.prev_cond);

  // Pointer is compared in BCD against the area's last word
  assign ind_err  = s.ind_ctrl[bcu_pkg::BCU_IND_EN_BIT]
                  & (s.ind_ctrl[bcu_pkg::BCU_IND_MISS_BIT]
                     | ~bcu_bcd_ok(s.ind_ptr)
                     | (s.ind_ptr > s.area_limit));
  assign col_err  = ~bcu_bcd_ok(s.column) | (s.column > bcu_pkg::BCU_MAX_COLUMN);
  assign area_err = ({1'b0, s.dest_base} + bcu_pkg::BCU_SET_SPAN)
                  > {1'b0, s.area_limit};
  assign add_err  = ~bcu_bcd_ok(s.src_lo) | ~bcu_bcd_ok(s.addend);
  assign cidx     = bcu_col_idx(s.column);
  assign neg16    = BCU_Z16 - s.src_lo;
  assign neg32    = bcu_pkg::BCU_ZERO32 - {s.src_hi, s.src_lo};
  assign bsum     = bcu_bcd_add(s.src_lo, s.addend, s.cy);

  // ----------------------------------------------------------------
  // Next state: bus slave, register writes, instruction execution
  // ----------------------------------------------------------------
  always_comb begin
    next_s     = s;
    // Single-wait answer; ack drops the cycle after it was given
    next_s.ack = req & ~s.ack;
    if (req & ~s.ack & ~wb_we_i) begin
      case (wadr)
        bcu_pkg::BCU_CTRL_OFS:       next_s.rdat = {27'h0, s.cond, s.diff, s.op};
        bcu_pkg::BCU_SRC_LO_OFS:     next_s.rdat = {16'h0, s.src_lo};
        bcu_pkg::BCU_SRC_HI_OFS:     next_s.rdat = {16'h0, s.src_hi};
        bcu_pkg::BCU_ADDEND_OFS:     next_s.rdat = {16'h0, s.addend};
        bcu_pkg::BCU_COLUMN_OFS:     next_s.rdat = {16'h0, s.column};
        bcu_pkg::BCU_DEST_BASE_OFS:  next_s.rdat = {16'h0, s.dest_base};
        bcu_pkg::BCU_AREA_LIMIT_OFS: next_s.rdat = {16'h0, s.area_limit};
        bcu_pkg::BCU_IND_CTRL_OFS:   next_s.rdat = {30'h0, s.ind_ctrl};
        bcu_pkg::BCU_IND_PTR_OFS:    next_s.rdat = {16'h0, s.ind_ptr};
        bcu_pkg::BCU_FLAGS_OFS:      next_s.rdat = {28'h0, s.er, s.uf, s.zf, s.cy};
        bcu_pkg::BCU_RES_LO_OFS:     next_s.rdat = {16'h0, s.res_lo};
        bcu_pkg::BCU_RES_HI_OFS:     next_s.rdat = {16'h0, s.res_hi};
        default: begin
          // Destination set window; anything else reads zero
          if (wadr[7:6] == bcu_pkg::BCU_COL_WIN) begin
            next_s.rdat = {16'h0, s.col[wadr[5:2]]};
          end else begin
            next_s.rdat = 32'h0;
          end
        end
      endcase
    end
    if (wr) begin
      case (wadr)
        bcu_pkg::BCU_SRC_LO_OFS:     next_s.src_lo = bcu_merge(s.src_lo, wb_dat_i, wb_sel_i);
        bcu_pkg::BCU_SRC_HI_OFS:     next_s.src_hi = bcu_merge(s.src_hi, wb_dat_i, wb_sel_i);
        bcu_pkg::BCU_ADDEND_OFS:     next_s.addend = bcu_merge(s.addend, wb_dat_i, wb_sel_i);
        bcu_pkg::BCU_COLUMN_OFS:     next_s.column = bcu_merge(s.column, wb_dat_i, wb_sel_i);
        bcu_pkg::BCU_DEST_BASE_OFS:
          next_s.dest_base = bcu_merge(s.dest_base, wb_dat_i, wb_sel_i);
        bcu_pkg::BCU_AREA_LIMIT_OFS:
          next_s.area_limit = bcu_merge(s.area_limit, wb_dat_i, wb_sel_i);
        bcu_pkg::BCU_IND_CTRL_OFS: begin
          if (wb_sel_i[0]) begin
            next_s.ind_ctrl = wb_dat_i[1:0];
          end
        end
        bcu_pkg::BCU_IND_PTR_OFS:    next_s.ind_ptr = bcu_merge(s.ind_ptr, wb_dat_i, wb_sel_i);
        // Software may preload carry ahead of a BCD add
        bcu_pkg::BCU_FLAGS_OFS: begin
          if (wb_sel_i[0]) begin
            next_s.cy = wb_dat_i[bcu_pkg::BCU_FLAG_CY_BIT];
          end
        end
        default: begin
          if (wadr[7:6] == bcu_pkg::BCU_COL_WIN) begin
            next_s.col[wadr[5:2]] = bcu_merge(s.col[wadr[5:2]], wb_dat_i, wb_sel_i);
          end
        end
      endcase
    end
    // Each control write is one scan of the selected instruction
    if (wr_ctrl) begin
      next_s.op        = new_op;
      next_s.diff      = new_diff;
      next_s.cond      = new_cond;
      next_s.prev_cond = new_cond;
      if (run) begin
        case (new_op)
          bcu_pkg::BCU_OP_SCATTER: begin
            if (ind_err | col_err | area_err) begin
              next_s.er = 1'b1;
            end else begin
              for (int i = 0; i < 16; i++) begin
                next_s.col[i][cidx] = s.src_lo[i];
              end
              next_s.zf = (s.src_lo == BCU_Z16);
              next_s.er = 1'b0;
            end
          end
          bcu_pkg::BCU_OP_NEG1: begin
            if (ind_err) begin
              next_s.er = 1'b1;
            end else begin
              next_s.res_lo = neg16;
              next_s.zf     = (neg16 == BCU_Z16);
              next_s.uf     = (s.src_lo == bcu_pkg::BCU_MIN_NEG16);
              next_s.er     = 1'b0;
            end
          end
          bcu_pkg::BCU_OP_NEG2: begin
            if (ind_err) begin
              next_s.er = 1'b1;
            end else begin
              next_s.res_lo = neg32[15:0];
              next_s.res_hi = neg32[31:16];
              next_s.zf     = (neg32 == bcu_pkg::BCU_ZERO32);
              next_s.uf     = ({s.src_hi, s.src_lo} == bcu_pkg::BCU_MIN_NEG32);
              next_s.er     = 1'b0;
            end
          end
          bcu_pkg::BCU_OP_SETC:    next_s.cy = 1'b1;
          bcu_pkg::BCU_OP_CLRC:    next_s.cy = 1'b0;
          bcu_pkg::BCU_OP_BCDADD: begin
            if (ind_err | add_err) begin
              next_s.er = 1'b1;
            end else begin
              next_s.res_lo = bsum[15:0];
              next_s.cy     = bsum[16];
              next_s.zf     = (bsum[15:0] == BCU_Z16);
              next_s.er     = 1'b0;
            end
          end
          default: next_s.op = new_op;
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      s            <= '0;
      s.area_limit <= bcu_pkg::BCU_LIMIT_RST;
    end else begin
      s <= next_s;
    end
  end

  assign wb_ack_o       = s.ack;
  assign wb_dat_o       = s.rdat;
  assign carry_flag     = s.cy;
  assign zero_flag      = s.zf;
  assign underflow_flag = s.uf;
  assign error_flag     = s.er;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rstn);

  logic fire_scat;
  logic fire_neg1;
  logic fire_neg2;
  logic fire_add;
  assign fire_scat = wr_ctrl & run & (new_op == bcu_pkg::BCU_OP_SCATTER);
  assign fire_neg1 = wr_ctrl & run & (new_op == bcu_pkg::BCU_OP_NEG1) & ~ind_err;
  assign fire_neg2 = wr_ctrl & run & (new_op == bcu_pkg::BCU_OP_NEG2) & ~ind_err;
  assign fire_add  = wr_ctrl & run & (new_op == bcu_pkg::BCU_OP_BCDADD);

  cond_low_hold_a: assert property (wr_ctrl & ~new_cond |=> $stable(s.col) && $stable({s.cy, s.zf, s.uf, s.er})) else $error("flags or set moved with condition low");
  scatter_bits_a: assert property (fire_scat & ~(ind_err | col_err | area_err) |=> s.col[0][$past(cidx)] == $past(s.src_lo[0]) && s.col[15][$past(cidx)] == $past(s.src_lo[15]) && s.zf == ($past(s.src_lo) == 16'h0000)) else $error("scatter column or zero flag wrong");
  scatter_err_a: assert property (fire_scat & (col_err | area_err) |=> s.er && $stable(s.col)) else $error("bad column or area not refused");
  neg_single_a: assert property (fire_neg1 |=> s.res_lo == 16'h0000 - $past(s.src_lo) && s.zf == (s.res_lo == 16'h0000) && s.uf == ($past(s.src_lo) == 16'h8000)) else $error("single negate wrong");
  neg_double_a: assert property (fire_neg2 |=> {s.res_hi, s.res_lo} == 32'h0 - {$past(s.src_hi), $past(s.src_lo)} && s.zf == ({s.res_hi, s.res_lo} == 32'h0) && s.uf == ({s.res_hi, s.res_lo} == 32'h8000_0000)) else $error("double negate wrong");
  indirect_err_a: assert property (wr_ctrl & run & ind_err & (new_op != bcu_pkg::BCU_OP_SETC) & (new_op != bcu_pkg::BCU_OP_CLRC) & (new_op != bcu_pkg::BCU_OP_NONE) |=> s.er) else $error("bad pointer not flagged");
  carry_ops_a: assert property (wr_ctrl & run & (new_op == bcu_pkg::BCU_OP_SETC) |=> s.cy ##2 (s.cy || $past(wr))) else $error("set carry failed");
  carry_clear_a: assert property (wr_ctrl & run & (new_op == bcu_pkg::BCU_OP_CLRC) |=> !s.cy) else $error("clear carry failed");
  bcd_add_a: assert property (fire_add & ~ind_err & ~add_err |=> s.res_lo == $past(bsum[15:0]) && s.cy == $past(bsum[16]) && s.zf == (s.res_lo == 16'h0000) && !s.er) else $error("bcd add wrong");
  bcd_add_err_a: assert property (fire_add & add_err |=> s.er && $stable(s.res_lo) && $stable(s.cy)) else $error("non-bcd add not refused");
  edge_only_a: assert property (wr_ctrl & new_diff & new_cond & s.prev_cond |=> $stable({s.cy, s.zf, s.uf, s.er, s.res_lo, s.res_hi})) else $error("edge form ran twice");

endmodule
`default_nettype wire

// [testbench/bcu_seq_model.sv]
`timescale 1ns/1ns
`default_nettype none
// ----------------------------------------------------------------
// Sequencer model: classic single-cycle bus master
// ----------------------------------------------------------------
module bcu_seq_model (
  input  wire logic        sys_clk,
  input  wire logic        rstn,
  input  wire logic        go,
  input  wire logic        go_we,
  input  wire logic [7:0]  go_adr,
  input  wire logic [31:0] go_dat,
  output logic             done,
  output logic      [31:0] got,
  output logic             cyc,
  output logic             stb,
  output logic             we,
  output logic      [7:0]  adr,
  output logic      [3:0]  sel,
  output logic      [31:0] dat,
  input  wire logic [31:0] dat_in,
  input  wire logic        ack
);
  // Request held until ack; released lines carry inverted junk so stale values never match
  always @(posedge sys_clk) begin
    done <= 1'b0;
    if (!rstn) begin
      // Quiet bus while reset is held; one process drives every output
      {cyc, stb, we, sel, adr, dat, got} <= 79'h0;
    end else if (cyc && ack) begin
      got <= dat_in;
      {cyc, stb, we} <= 3'h0;
      adr <= ~adr;
      sel <= ~sel;
      dat <= ~dat;
      done <= 1'b1;
    end else if (rstn && !cyc && go) begin
      {cyc, stb, we} <= {2'h3, go_we};
      adr <= go_adr;
      sel <= 4'h3;
      dat <= go_dat;
    end
  end
endmodule
`default_nettype wire

// [testbench/tb_top.sv]
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  // ----------------------------------------------------------------
  // Bench signals
  // ----------------------------------------------------------------
  logic        sys_clk;
  logic        rstn;
  logic        go;
  logic        go_we;
  logic [7:0]  go_adr;
  logic [31:0] go_dat;
  logic        done;
  logic [31:0] rd;
  logic        cyc, stb, we, ack, cy, zf, uf, er, ci;
  logic [7:0]  adr;
  logic [3:0]  sel;
  logic [31:0] wdat, rdat, d;
  logic [15:0] a, b;
  logic [16:0] s;
  logic [15:0] exp_set [16];
  int          failures = 0;
  int          compares = 0;
  int          seed, c;

  bcu_unit uut (.sys_clk(sys_clk), .rstn(rstn), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat),
    .wb_ack_o(ack), .carry_flag(cy), .zero_flag(zf), .underflow_flag(uf), .error_flag(er));
  bcu_seq_model seq (.sys_clk(sys_clk), .rstn(rstn), .go(go), .go_we(go_we), .go_adr(go_adr),
    .go_dat(go_dat), .done(done), .got(rd), .cyc(cyc), .stb(stb), .we(we), .adr(adr),
    .sel(sel), .dat(wdat), .dat_in(rdat), .ack(ack));

  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end

  // Watchdog: the full sequence needs well under this span
  initial begin
    #400000;
    failures++;
    finish_test();
  end

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  task automatic finish_test();
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      failures++;
      $display("MISMATCH %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // One bus cycle through the model; bounded wait on its done pulse
  task automatic bus(input logic w, input logic [7:0] at, input logic [31:0] v);
    int n;
    @(posedge sys_clk);
    go_we <= w;
    go_adr <= at;
    go_dat <= v;
    go <= 1'b1;
    @(posedge sys_clk);
    go <= 1'b0;
    n = 0;
    while (done !== 1'b1 && n < 40) begin
      @(posedge sys_clk);
      n++;
    end
    if (n >= 40) failures++;
  endtask

  task automatic op(input logic [2:0] code, input logic diff, input logic cond);
    bus(1'b1, bcu_pkg::BCU_CTRL_OFS, {27'h0, cond, diff, code});
  endtask

  function automatic logic is_bcd(input logic [15:0] v);
    is_bcd = 1'b1;
    for (int j = 0; j < 4; j++) if (v[4*j +: 4] > 4'h9) is_bcd = 1'b0;
  endfunction

  // Digit-serial decimal sum, carry out in bit 16
  function automatic logic [16:0] bcd_sum(input logic [15:0] x, input logic [15:0] y,
                                          input logic cin);
    logic [4:0] t;
    bcd_sum[16] = cin;
    for (int j = 0; j < 4; j++) begin
      t = {1'b0, x[4*j +: 4]} + {1'b0, y[4*j +: 4]} + {4'h0, bcd_sum[16]};
      bcd_sum[16] = (t > 5'h09);
      bcd_sum[4*j +: 4] = bcd_sum[16] ? 4'(t - 5'h0a) : t[3:0];
    end
  endfunction

  function automatic logic [15:0] rnd_bcd();
    for (int j = 0; j < 4; j++) rnd_bcd[4*j +: 4] = 4'($urandom_range(9));
  endfunction

  task automatic check_set();
    for (int j = 0; j < 16; j++) begin
      bus(1'b0, 8'h40 + 8'(4 * j), 32'h0);
      check("set_word", rd, {16'h0, exp_set[j]});
    end
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    rstn = 1'b0;
    go = 1'b0;
    go_we = 1'b0;
    go_adr = 8'h00;
    go_dat = 32'h0;
    seed = $urandom(12408);
    for (int j = 0; j < 16; j++) exp_set[j] = 16'h0;
    repeat (2) @(posedge sys_clk);
    rstn <= 1'b1;
    bus(1'b0, bcu_pkg::BCU_AREA_LIMIT_OFS, 32'h0);
    check("area_limit", rd, {16'h0, bcu_pkg::BCU_LIMIT_RST});
    bus(1'b0, 8'h30, 32'h0);
    check("unmapped", rd, 32'h0);
    $display("test reset done");
    // Carry ops with condition low first: must be no-ops
    op(bcu_pkg::BCU_OP_SETC, 1'b0, 1'b0);
    check("carry", cy, 1'b0);
    op(bcu_pkg::BCU_OP_SETC, 1'b0, 1'b1);
    check("carry", cy, 1'b1);
    bus(1'b0, bcu_pkg::BCU_FLAGS_OFS, 32'h0);
    check("flags", rd, 32'h1);
    op(bcu_pkg::BCU_OP_CLRC, 1'b0, 1'b0);
    check("carry", cy, 1'b1);
    op(bcu_pkg::BCU_OP_CLRC, 1'b0, 1'b1);
    check("carry", cy, 1'b0);
    $display("test carry done");
    for (int k = 0; k < 20; k++) begin
      a = (k == 0) ? 16'h0 : (k == 1) ? 16'h8000 : 16'($urandom);
      bus(1'b1, bcu_pkg::BCU_SRC_LO_OFS, {16'h0, a});
      op(bcu_pkg::BCU_OP_NEG1, 1'b0, 1'b1);
      bus(1'b0, bcu_pkg::BCU_RES_LO_OFS, 32'h0);
      check("neg16", rd, {16'h0, 16'h0 - a});
      check("neg16_zero", zf, a == 16'h0);
      check("neg16_uf", uf, a == 16'h8000);
    end
    $display("test negate16 done");
    // Low-half-zero case shows the zero test spans both halves
    for (int k = 0; k < 20; k++) begin
      d = (k == 0) ? 32'h0 : (k == 1) ? 32'h8000_0000 : (k == 2) ? 32'h0001_0000 : $urandom;
      // Source and result pairs each stay in one register window
      bus(1'b1, bcu_pkg::BCU_SRC_LO_OFS, {16'h0, d[15:0]});
      bus(1'b1, bcu_pkg::BCU_SRC_HI_OFS, {16'h0, d[31:16]});
      op(bcu_pkg::BCU_OP_NEG2, 1'b0, 1'b1);
      bus(1'b0, bcu_pkg::BCU_RES_LO_OFS, 32'h0);
      b = rd[15:0];
      bus(1'b0, bcu_pkg::BCU_RES_HI_OFS, 32'h0);
      check("neg32", {rd[15:0], b}, 32'h0 - d);
      check("neg32_zero", zf, d == 32'h0);
      check("neg32_uf", uf, d == 32'h8000_0000);
    end
    $display("test negate32 done");
    for (int k = 0; k < 20; k++) begin
      a = (k == 0) ? 16'h9999 : (k == 1) ? 16'h0 : rnd_bcd();
      b = (k < 2) ? 16'h0 : rnd_bcd();
      ci = (k == 0) ? 1'b1 : (k == 1) ? 1'b0 : 1'($urandom_range(1));
      op(ci ? bcu_pkg::BCU_OP_SETC : bcu_pkg::BCU_OP_CLRC, 1'b0, 1'b1);
      bus(1'b1, bcu_pkg::BCU_SRC_LO_OFS, {16'h0, a});
      bus(1'b1, bcu_pkg::BCU_ADDEND_OFS, {16'h0, b});
      op(bcu_pkg::BCU_OP_BCDADD, 1'b0, 1'b1);
      bus(1'b0, bcu_pkg::BCU_RES_LO_OFS, 32'h0);
      s = bcd_sum(a, b, ci);
      check("bcd_sum", rd, {16'h0, s[15:0]});
      check("bcd_carry", cy, s[16]);
      check("bcd_zero", zf, s[15:0] == 16'h0);
      check("bcd_err", er, 1'b0);
    end
    // A bad digit in augend, then in addend
    for (int k = 0; k < 2; k++) begin
      bus(1'b1, bcu_pkg::BCU_SRC_LO_OFS, (k == 0) ? 32'h00a0 : 32'h1234);
      bus(1'b1, bcu_pkg::BCU_ADDEND_OFS, (k == 0) ? 32'h0001 : 32'h1f00);
      op(bcu_pkg::BCU_OP_BCDADD, 1'b0, 1'b1);
      check("bcd_err", er, 1'b1);
    end
    $display("test bcd add done");
    // Base kept clear of the reserved upper words
    bus(1'b1, bcu_pkg::BCU_DEST_BASE_OFS, 32'h0100);
    for (int k = 0; k < 10; k++) begin
      c = (k == 0) ? 0 : (k == 1) ? 15 : $urandom_range(15);
      a = (k == 2) ? 16'h0 : 16'($urandom);
      bus(1'b1, bcu_pkg::BCU_COLUMN_OFS, 32'((c < 10) ? c : c + 6));
      bus(1'b1, bcu_pkg::BCU_SRC_LO_OFS, {16'h0, a});
      op(bcu_pkg::BCU_OP_SCATTER, 1'b0, 1'b1);
      for (int j = 0; j < 16; j++) exp_set[j][c] = a[j];
      check("col_zero", zf, a == 16'h0);
      check("col_err", er, 1'b0);
      check_set();
    end
    // Column 16, a non-BCD digit, and 100: error and no write
    for (int k = 0; k < 3; k++) begin
      bus(1'b1, bcu_pkg::BCU_COLUMN_OFS, (k == 0) ? 32'h16 : (k == 1) ? 32'h0a : 32'h100);
      bus(1'b1, bcu_pkg::BCU_SRC_LO_OFS, 32'hffff);
      op(bcu_pkg::BCU_OP_SCATTER, 1'b0, 1'b1);
      check("col_err", er, 1'b1);
      check_set();
    end
    bus(1'b1, bcu_pkg::BCU_COLUMN_OFS, 32'h3);
    op(bcu_pkg::BCU_OP_SCATTER, 1'b0, 1'b0);
    check("col_idle", er, 1'b1);
    check_set();
    // Last word on the limit passes, one past it fails
    bus(1'b1, bcu_pkg::BCU_AREA_LIMIT_OFS, 32'h01ff);
    for (int k = 0; k < 2; k++) begin
      bus(1'b1, bcu_pkg::BCU_DEST_BASE_OFS, 32'h01f0 + 32'(k));
      op(bcu_pkg::BCU_OP_SCATTER, 1'b0, 1'b1);
      if (k == 0) for (int j = 0; j < 16; j++) exp_set[j][3] = 1'b1;
      check("area_err", er, k == 1);
      check_set();
    end
    $display("test scatter done");
    // Missing word, non-BCD pointer, pointer past the limit, then a good one
    for (int k = 0; k < 4; k++) begin
      b = (k == 1) ? 16'h00a0 : (k == 2) ? 16'h0200 : 16'h0199;
      bus(1'b1, bcu_pkg::BCU_IND_CTRL_OFS, (k == 0) ? 32'h3 : 32'h1);
      bus(1'b1, bcu_pkg::BCU_IND_PTR_OFS, {16'h0, b});
      op(bcu_pkg::BCU_OP_NEG1, 1'b0, 1'b1);
      check("ind_err", er, (k == 0) || !is_bcd(b) || (b > 16'h01ff));
    end
    bus(1'b1, bcu_pkg::BCU_IND_CTRL_OFS, 32'h0);
    $display("test indirect done");
    // Differentiated: runs on the rising scan only
    op(bcu_pkg::BCU_OP_NEG1, 1'b1, 1'b0);
    for (int k = 0; k < 3; k++) begin
      if (k == 2) op(bcu_pkg::BCU_OP_NEG1, 1'b1, 1'b0);
      bus(1'b1, bcu_pkg::BCU_SRC_LO_OFS, 32'(k + 1));
      op(bcu_pkg::BCU_OP_NEG1, 1'b1, 1'b1);
      bus(1'b0, bcu_pkg::BCU_RES_LO_OFS, 32'h0);
      check("diff", rd, (k == 2) ? 32'hfffd : 32'hffff);
    end
    $display("test differentiated done");
    finish_test();
  end
endmodule
`default_nettype wire
